/* File: acr_axil_slave.sv */
// axi4-lite slave turning bus accesses into register strobes
// assumes one outstanding write and one outstanding read
`timescale 1ns/10ps
`default_nettype none
`include "acr_cfg.svh"

module acr_axil_slave (
   input  wire logic                   clk_i,      // core clock
   input  wire logic                   rst_i,      // async reset, high
   input  wire logic [`ACR_ADDR_W-1:0] awaddr_i,   // write address
   input  wire logic                   awvalid_i,  // write address valid
   output logic                        awready_o,  // write address ready
   input  wire logic [31:0]            wdata_i,    // write data
   input  wire logic [3:0]             wstrb_i,    // byte enables
   input  wire logic                   wvalid_i,   // write data valid
   output logic                        wready_o,   // write data ready
   output logic [1:0]                  bresp_o,    // write response
   output logic                        bvalid_o,   // response valid
   input  wire logic                   bready_i,   // response ready
   input  wire logic [`ACR_ADDR_W-1:0] araddr_i,   // read address
   input  wire logic                   arvalid_i,  // read address valid
   output logic                        arready_o,  // read address ready
   output logic [31:0]                 rdata_o,    // read data
   output logic [1:0]                  rresp_o,    // read response
   output logic                        rvalid_o,   // read valid
   input  wire logic                   rready_i,   // read ready
   acr_reg_if.bus                      regs        // register strobes
);

   logic                   aw_held_q;
   logic [`ACR_ADDR_W-1:0] aw_addr_q;
   logic                   w_held_q;
   logic [7:0]             w_data_q;
   logic                   w_lane0_q;
   acr_pkg::acr_wr_state_t wr_state_q;
   acr_pkg::acr_rd_state_t rd_state_q;
   logic                   do_write;

   // ------------------------------------------------------------
   // write path: address and data caught in either order
   // ------------------------------------------------------------
   assign awready_o = (wr_state_q == acr_pkg::ACR_WR_IDLE) && !aw_held_q;
   assign wready_o  = (wr_state_q == acr_pkg::ACR_WR_IDLE) && !w_held_q;
   assign do_write  = aw_held_q && w_held_q && (wr_state_q == acr_pkg::ACR_WR_IDLE);

   // only the low byte lane carries register data
   assign regs.wr_en   = do_write && w_lane0_q;
   assign regs.wr_idx  = aw_addr_q[9:2];
   assign regs.wr_data = w_data_q;

   // address and data holding
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_held_q  <= 1'b0;
         w_data_q  <= 8'h00;
         w_lane0_q <= 1'b0;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_held_q  <= 1'b1;
            w_data_q  <= wdata_i[7:0];
            w_lane0_q <= wstrb_i[0];
         end
      end
   end

   // write response
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_state_q <= acr_pkg::ACR_WR_IDLE;
         bvalid_o   <= 1'b0;
         bresp_o    <= `ACR_RESP_OKAY;
      end else begin
         case (wr_state_q)
            acr_pkg::ACR_WR_IDLE: begin
               if (do_write) begin
                  wr_state_q <= acr_pkg::ACR_WR_RESP;
                  bvalid_o   <= 1'b1;
                  bresp_o    <= regs.wr_ok ? `ACR_RESP_OKAY : `ACR_RESP_DECERR;
               end
            end
            acr_pkg::ACR_WR_RESP: begin
               if (bready_i) begin
                  wr_state_q <= acr_pkg::ACR_WR_IDLE;
                  bvalid_o   <= 1'b0;
               end
            end
            default: begin
               wr_state_q <= acr_pkg::ACR_WR_IDLE;
               bvalid_o   <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // read path: data registered one cycle after the address
   // ------------------------------------------------------------
   assign arready_o   = (rd_state_q == acr_pkg::ACR_RD_IDLE);
   assign regs.rd_en  = arvalid_i && arready_o;
   assign regs.rd_idx = araddr_i[9:2];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_state_q <= acr_pkg::ACR_RD_IDLE;
         rvalid_o   <= 1'b0;
         rdata_o    <= 32'h0000_0000;
         rresp_o    <= `ACR_RESP_OKAY;
      end else begin
         case (rd_state_q)
            acr_pkg::ACR_RD_IDLE: begin
               if (regs.rd_en) begin
                  rd_state_q <= acr_pkg::ACR_RD_DATA;
                  rvalid_o   <= 1'b1;
                  rdata_o    <= regs.rd_ok ? {24'h00_0000, regs.rd_data} : 32'h0000_0000;
                  rresp_o    <= regs.rd_ok ? `ACR_RESP_OKAY : `ACR_RESP_DECERR;
               end
            end
            acr_pkg::ACR_RD_DATA: begin
               if (rready_i) begin
                  rd_state_q <= acr_pkg::ACR_RD_IDLE;
                  rvalid_o   <= 1'b0;
               end
            end
            default: begin
               rd_state_q <= acr_pkg::ACR_RD_IDLE;
               rvalid_o   <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

/* File: acr_cfg.svh */
// constants for the accumulator config latch and id register block
// assumes a 32-bit axi4-lite slave, byte addresses = index * 4
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// ------------------------------------------------------------
// register indices (printed offsets) and bus address width
// ------------------------------------------------------------
`define ACR_IDX_STAGE      8'h25
`define ACR_IDX_ACTIVE     8'h4A
`define ACR_IDX_LATCHED    8'h4B
`define ACR_IDX_PRODUCT    8'hFD
`define ACR_IDX_MAKER      8'hFE
`define ACR_IDX_REVISION   8'hFF
`define ACR_IDX_SNAPSHOT   8'h80
`define ACR_IDX_STATUS     8'h81
`define ACR_ADDR_W         10

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define ACR_CH_COUNT       4
`define ACR_SRC_W          2
`define ACR_CFG_RESET      8'h00
`define ACR_SNAP_VAR_W     2

// ------------------------------------------------------------
// identification values (arbitrary neutral values)
// ------------------------------------------------------------
`define ACR_PRODUCT_CODE   8'hA5
`define ACR_MAKER_CODE     8'h3C
`define ACR_REVISION_CODE  8'h01

// ------------------------------------------------------------
// timing: results valid 1 ms after snapshot, clock 20 MHz
// ------------------------------------------------------------
`define ACR_CLK_HZ         20000000
`define ACR_VALID_DELAY_US 1000
`define ACR_VALID_CYCLES   ((`ACR_CLK_HZ / 1000000) * `ACR_VALID_DELAY_US)

// ------------------------------------------------------------
// axi response codes
// ------------------------------------------------------------
`define ACR_RESP_OKAY      2'h0
`define ACR_RESP_SLVERR    2'h2
`define ACR_RESP_DECERR    2'h3

`endif

/* File: acr_pkg.sv */
// types for the accumulator config latch and id register block
// assumes acr_cfg.svh supplies the numeric constants
`include "acr_cfg.svh"

package acr_pkg;

   // per-channel accumulator source code
   typedef enum logic [1:0] {
      ACR_SRC_POWER = 2'b00,
      ACR_SRC_SHUNT = 2'b01,
      ACR_SRC_RAIL  = 2'b10,
      ACR_SRC_RSVD  = 2'b11
   } acr_src_t;

   // bus write channel state
   typedef enum logic [1:0] {
      ACR_WR_IDLE = 2'b00,
      ACR_WR_RESP = 2'b01
   } acr_wr_state_t;

   // read channel state
   typedef enum logic [1:0] {
      ACR_RD_IDLE = 2'b00,
      ACR_RD_DATA = 2'b01
   } acr_rd_state_t;

endpackage

/* File: acr_reg_if.sv */
// register access strobes between the bus slave and the register core
// assumes single clock, strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none

interface acr_reg_if;
   logic       wr_en;    // write strobe
   logic [7:0] wr_idx;   // register index
   logic [7:0] wr_data;  // write data, low byte
   logic       wr_ok;    // index accepted for write
   logic       rd_en;    // read strobe
   logic [7:0] rd_idx;   // register index
   logic [7:0] rd_data;  // read data, combinational
   logic       rd_ok;    // index is mapped

   modport bus (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
                input  wr_ok, rd_data, rd_ok);
   modport core (input  wr_en, wr_idx, wr_data, rd_en, rd_idx,
                 output wr_ok, rd_data, rd_ok);
endinterface

`default_nettype wire

/* File: acr_top.sv */
// accumulator source configuration latch and identification registers
// assumes axi4-lite master, one write and one read outstanding at most
//
// Behaviour
// - every snapshot variant copies the settings in force into the latched register
// - staged settings take effect only on a snapshot; active register shows them
// - latched settings match result data, valid 1 ms after a snapshot
// - latched byte: ch1 bits 7-6, ch2 5-4, ch3 3-2, ch4 1-0
// - source code 00 power, 01 shunt voltage, 10 rail voltage
// - reserved code 11 reads back as zero
// - latched register is all zero after reset
// - read-only product code register at index FD
// - read-only maker code register at index FE
// - read-only die revision register at index FF
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "acr_cfg.svh"

module acr_top #(
   parameter int unsigned VALID_CYCLES = `ACR_VALID_CYCLES  // result-valid wait
) (
   input  wire logic                   CORE_CLK_I,       // core clock, 20 MHz
   input  wire logic                   RESET_I,          // async reset, high
   input  wire logic [`ACR_ADDR_W-1:0] S_AXI_AWADDR_I,   // write address
   input  wire logic                   S_AXI_AWVALID_I,  // write address valid
   output logic                        S_AXI_AWREADY_O,  // write address ready
   input  wire logic [31:0]            S_AXI_WDATA_I,    // write data
   input  wire logic [3:0]             S_AXI_WSTRB_I,    // byte enables
   input  wire logic                   S_AXI_WVALID_I,   // write data valid
   output logic                        S_AXI_WREADY_O,   // write data ready
   output logic [1:0]                  S_AXI_BRESP_O,    // write response
   output logic                        S_AXI_BVALID_O,   // write response valid
   input  wire logic                   S_AXI_BREADY_I,   // write response ready
   input  wire logic [`ACR_ADDR_W-1:0] S_AXI_ARADDR_I,   // read address
   input  wire logic                   S_AXI_ARVALID_I,  // read address valid
   output logic                        S_AXI_ARREADY_O,  // read address ready
   output logic [31:0]                 S_AXI_RDATA_O,    // read data
   output logic [1:0]                  S_AXI_RRESP_O,    // read response
   output logic                        S_AXI_RVALID_O,   // read valid
   input  wire logic                   S_AXI_RREADY_I,   // read ready
   output logic [7:0]                  ACTIVE_SRC_O,     // settings in force
   output logic                        RESULTS_VALID_O   // latched set valid
);

   acr_reg_if regs ();

   logic [7:0] stage_q;
   logic [7:0] active_q;
   logic [7:0] latched_q;
   logic       snap_pulse;
   logic [1:0] snap_kind_q;
   logic       results_valid;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------

   // reserved source code collapses to zero on read-back
   function automatic logic [7:0] acr_clean(input logic [7:0] raw);
      logic [7:0] res;
      res = raw;
      for (int i = 0; i < `ACR_CH_COUNT; i++) begin
         if (raw[2*i +: 2] == acr_pkg::ACR_SRC_RSVD) begin
            res[2*i +: 2] = acr_pkg::ACR_SRC_POWER;
         end
      end
      return res;
   endfunction

   // true for the three constant identification indices
   function automatic logic acr_is_ident(input logic [7:0] idx);
      return (idx == `ACR_IDX_PRODUCT) || (idx == `ACR_IDX_MAKER)
          || (idx == `ACR_IDX_REVISION);
   endfunction

   // ------------------------------------------------------------
   // bus slave and result-valid timer
   // ------------------------------------------------------------
   acr_axil_slave u_bus (
      .clk_i     (CORE_CLK_I),
      .rst_i     (RESET_I),
      .awaddr_i  (S_AXI_AWADDR_I),
      .awvalid_i (S_AXI_AWVALID_I),
      .awready_o (S_AXI_AWREADY_O),
      .wdata_i   (S_AXI_WDATA_I),
      .wstrb_i   (S_AXI_WSTRB_I),
      .wvalid_i  (S_AXI_WVALID_I),
      .wready_o  (S_AXI_WREADY_O),
      .bresp_o   (S_AXI_BRESP_O),
      .bvalid_o  (S_AXI_BVALID_O),
      .bready_i  (S_AXI_BREADY_I),
      .araddr_i  (S_AXI_ARADDR_I),
      .arvalid_i (S_AXI_ARVALID_I),
      .arready_o (S_AXI_ARREADY_O),
      .rdata_o   (S_AXI_RDATA_O),
      .rresp_o   (S_AXI_RRESP_O),
      .rvalid_o  (S_AXI_RVALID_O),
      .rready_i  (S_AXI_RREADY_I),
      .regs      (regs.bus)
   );

   // latched set is only trustworthy once the results are
   acr_valid_timer #(
      .VALID_CYCLES (VALID_CYCLES)
   ) u_timer (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RESET_I),
      .start_i (snap_pulse),
      .valid_o (results_valid)
   );

   // ------------------------------------------------------------
   // snapshot command and configuration registers
   // ------------------------------------------------------------

   // any write with byte lane 0 enabled to the snapshot index is a snapshot; data picks the variant
   assign snap_pulse = regs.wr_en && (regs.wr_idx == `ACR_IDX_SNAPSHOT);

   // variant recorded for status only; all variants latch alike
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         snap_kind_q <= 2'h0;
      end else if (snap_pulse) begin
         snap_kind_q <= regs.wr_data[`ACR_SNAP_VAR_W-1:0];
      end
   end

   // staging register, software owned
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         stage_q <= `ACR_CFG_RESET;
      end else if (regs.wr_en && regs.wr_idx == `ACR_IDX_STAGE) begin
         stage_q <= regs.wr_data;
      end
   end

   // staged settings go live only on a snapshot
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         active_q <= `ACR_CFG_RESET;
      end else if (snap_pulse) begin
         active_q <= stage_q;
      end
   end

   // latched copy of what was in force just before the snapshot
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         latched_q <= `ACR_CFG_RESET;
      end else if (snap_pulse) begin
         latched_q <= active_q;
      end
   end

   // ------------------------------------------------------------
   // write acceptance and read mux
   // ------------------------------------------------------------

   // identification indices answer okay but keep their values
   assign regs.wr_ok = (regs.wr_idx == `ACR_IDX_STAGE)
                    || (regs.wr_idx == `ACR_IDX_SNAPSHOT)
                    || acr_is_ident(regs.wr_idx);

   // read data per index; unmapped indices flagged for a decode error
   always_comb begin
      regs.rd_ok   = 1'b1;
      regs.rd_data = 8'h00;
      case (regs.rd_idx)
         `ACR_IDX_STAGE:    regs.rd_data = acr_clean(stage_q);
         `ACR_IDX_ACTIVE:   regs.rd_data = acr_clean(active_q);
         `ACR_IDX_LATCHED:  regs.rd_data = acr_clean(latched_q);
         `ACR_IDX_PRODUCT:  regs.rd_data = `ACR_PRODUCT_CODE;
         `ACR_IDX_MAKER:    regs.rd_data = `ACR_MAKER_CODE;
         `ACR_IDX_REVISION: regs.rd_data = `ACR_REVISION_CODE;
         `ACR_IDX_STATUS:   regs.rd_data = {5'h00, snap_kind_q, results_valid};
         default:           regs.rd_ok   = 1'b0;
      endcase
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign ACTIVE_SRC_O    = active_q;
   assign RESULTS_VALID_O = results_valid;

endmodule

`default_nettype wire

/* File: acr_top_props.sv */
// checker for the config latch and id register block
// assumes it is bound onto acr_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
`include "acr_cfg.svh"

module acr_top_props #(
   parameter int unsigned VALID_CYCLES = 20000  // result-valid wait
) (
   input wire logic        CORE_CLK_I,       // core clock
   input wire logic        RESET_I,          // async reset, high
   input wire logic        S_AXI_AWVALID_I,  // write address valid
   input wire logic        S_AXI_AWREADY_O,  // write address ready
   input wire logic        S_AXI_WVALID_I,   // write data valid
   input wire logic        S_AXI_WREADY_O,   // write data ready
   input wire logic [1:0]  S_AXI_BRESP_O,    // write response
   input wire logic        S_AXI_BVALID_O,   // write response valid
   input wire logic        S_AXI_BREADY_I,   // write response ready
   input wire logic        S_AXI_ARVALID_I,  // read address valid
   input wire logic        S_AXI_ARREADY_O,  // read address ready
   input wire logic [31:0] S_AXI_RDATA_O,    // read data
   input wire logic [1:0]  S_AXI_RRESP_O,    // read response
   input wire logic        S_AXI_RVALID_O,   // read valid
   input wire logic        S_AXI_RREADY_I,   // read ready
   input wire logic [7:0]  ACTIVE_SRC_O,     // settings in force
   input wire logic        RESULTS_VALID_O   // latched set valid
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);

   // ----------------------------------------------------------
   // helper: cycles since results went stale
   // ----------------------------------------------------------
   logic        bvalid_q;   // previous response valid
   logic [31:0] low_cnt_q;  // stale-cycle count

   // restarts on each write response, since only writes can snapshot
   always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         bvalid_q  <= 1'b0;
         low_cnt_q <= 32'h0000_0000;
      end else begin
         bvalid_q <= S_AXI_BVALID_O;
         if (RESULTS_VALID_O || (S_AXI_BVALID_O && !bvalid_q)) begin
            low_cnt_q <= 32'h0000_0000;
         end else begin
            low_cnt_q <= low_cnt_q + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   a_write_latency: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
      && S_AXI_WREADY_O |-> ##2 $rose(S_AXI_BVALID_O))
      else $error("write response late");
   a_bresp_legal: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O inside {2'h0, 2'h3})
      else $error("bad write response code");
   a_bvalid_clears: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
      else $error("write response not retired");
   a_read_latency: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
      else $error("read data late");
   a_read_blocks: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read taken while data pending");
   a_rdata_byte: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h00_0000
      && (S_AXI_RRESP_O != 2'h3 || S_AXI_RDATA_O == 32'h0000_0000))
      else $error("read data outside low byte");
   a_active_on_write: assert property ($changed(ACTIVE_SRC_O) |-> $rose(S_AXI_BVALID_O))
      else $error("settings changed without a write");
   a_valid_delay: assert property ($rose(RESULTS_VALID_O) |-> low_cnt_q == VALID_CYCLES - 1)
      else $error("results valid at wrong time");
   a_reset_clear: assert property ($fell(RESET_I) |-> ACTIVE_SRC_O == 8'h00
      && !RESULTS_VALID_O)
      else $error("state not cleared by reset");

   c_snapshot: cover property ($rose(RESULTS_VALID_O));
   c_write: cover property ($rose(S_AXI_BVALID_O));
   c_decerr: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h3);
endmodule

bind acr_top acr_top_props #(.VALID_CYCLES(VALID_CYCLES)) u_props (
   .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
   .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
   .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .S_AXI_RREADY_I(S_AXI_RREADY_I), .ACTIVE_SRC_O(ACTIVE_SRC_O),
   .RESULTS_VALID_O(RESULTS_VALID_O)
);

`default_nettype wire

/* File: acr_valid_timer.sv */
// counts out the result-valid delay after each snapshot
// assumes a restart pulse of one cycle; a new snapshot restarts the wait
`timescale 1ns/10ps
`default_nettype none

module acr_valid_timer #(
   parameter int unsigned VALID_CYCLES = 20000  // cycles until results valid
) (
   input  wire logic clk_i,     // core clock
   input  wire logic rst_i,     // async reset, high
   input  wire logic start_i,   // snapshot taken
   output logic      valid_o    // results and latched config valid
);

   logic [31:0] count_q;

   // count down; valid once the wait is over
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= 32'h0000_0000;
      end else if (start_i) begin
         count_q <= VALID_CYCLES[31:0];
      end else if (count_q != 32'h0000_0000) begin
         count_q <= count_q - 32'h0000_0001;
      end
   end

   // registered so the output carries no decode glitch
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
      end else begin
         valid_o <= !start_i && (count_q == 32'h0000_0001 || (valid_o && count_q == 32'h0000_0000));
      end
   end

endmodule

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the config latch and id register block
// assumes acr_top with the checker bound; bench acts as axi4-lite master
`timescale 1ns/10ps
`default_nettype none
`include "acr_cfg.svh"

module tb_top;
   localparam int unsigned VC = 8;  // short valid wait keeps the run brief
   logic        clk, rst, aw_valid, w_valid, ar_valid, b_ready, r_ready;
   logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, res_valid;
   logic [9:0]  aw_addr, ar_addr;
   logic [31:0] w_data, r_data;
   logic [3:0]  w_strb;
   logic [1:0]  b_resp, r_resp;
   logic [7:0]  active;
   int          n_mismatch, total_checks;

   acr_top #(.VALID_CYCLES(VC)) dut (
      .CORE_CLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(aw_addr),
      .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_ready), .S_AXI_WDATA_I(w_data),
      .S_AXI_WSTRB_I(w_strb), .S_AXI_WVALID_I(w_valid), .S_AXI_WREADY_O(w_ready),
      .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid), .S_AXI_BREADY_I(b_ready),
      .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid), .S_AXI_ARREADY_O(ar_ready),
      .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_valid),
      .S_AXI_RREADY_I(r_ready), .ACTIVE_SRC_O(active), .RESULTS_VALID_O(res_valid)
   );

   always #25 clk = ~clk;

   // ----------------------------------------------------------
   // compare, bus and closing tasks
   // ----------------------------------------------------------
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("Error %0t: got %h expected %h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ready read at the taking edge, before the design updates its state
   task automatic axi_write(input logic [7:0] idx, input logic [31:0] data,
                            output logic [1:0] resp);
      logic da, dw;
      da = 1'b0;
      dw = 1'b0;
      aw_addr  <= {idx, 2'b00};
      w_data   <= data;
      aw_valid <= 1'b1;
      w_valid  <= 1'b1;
      do begin
         @(posedge clk);
         da = da | aw_ready;
         dw = dw | w_ready;
         if (da) aw_valid <= 1'b0;
         if (dw) w_valid <= 1'b0;
      end while (!(da && dw));
      do @(posedge clk); while (!b_valid);
      resp = b_resp;
   endtask

   task automatic axi_read(input logic [7:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
      ar_addr  <= {idx, 2'b00};
      ar_valid <= 1'b1;
      do @(posedge clk); while (!ar_ready);
      ar_valid <= 1'b0;
      do @(posedge clk); while (!r_valid);
      data = r_data;
      resp = r_resp;
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(idx, d, r);
      cmp_word(d, {24'h00_0000, exp});
      cmp_word(32'(r), 32'(er));
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_reset_values;
      cmp_word(32'(active), 32'h0000_0000);
      cmp_word(32'(res_valid), 32'h0000_0000);
      rd_chk(`ACR_IDX_LATCHED, 8'h00, `ACR_RESP_OKAY);
      rd_chk(`ACR_IDX_ACTIVE, 8'h00, `ACR_RESP_OKAY);
   endtask

   task automatic t_ident;
      logic [7:0] idx [3] = '{`ACR_IDX_PRODUCT, `ACR_IDX_MAKER, `ACR_IDX_REVISION};
      logic [7:0] code [3] = '{`ACR_PRODUCT_CODE, `ACR_MAKER_CODE, `ACR_REVISION_CODE};
      logic [1:0] r;
      for (int i = 0; i < 3; i++) begin
         rd_chk(idx[i], code[i], `ACR_RESP_OKAY);
         axi_write(idx[i], {24'h00_0000, ~code[i]}, r);
         cmp_word(32'(r), 32'(`ACR_RESP_OKAY));
         rd_chk(idx[i], code[i], `ACR_RESP_OKAY);
      end
   endtask

   // each variant; latched shows the set in force before it
   task automatic t_snapshots;
      logic [7:0] stage [4] = '{8'h1B, 8'h64, 8'hB1, 8'h00};  // all four codes
      logic [7:0] view [4] = '{8'h18, 8'h64, 8'h81, 8'h00};  // 11 reads as 00
      logic [7:0] prev, pv;
      logic [1:0] r;
      int         n;
      prev = 8'h00;
      pv = 8'h00;
      for (int v = 0; v < 4; v++) begin
         axi_write(`ACR_IDX_STAGE, {24'h00_0000, stage[v]}, r);
         cmp_word(32'(active), 32'(prev));
         rd_chk(`ACR_IDX_STAGE, view[v], `ACR_RESP_OKAY);
         axi_write(`ACR_IDX_SNAPSHOT, 32'(v), r);
         cmp_word(32'(active), 32'(stage[v]));
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (!res_valid && n < 100);
         cmp_word(32'(n), VC);
         @(posedge clk);
         rd_chk(`ACR_IDX_ACTIVE, view[v], `ACR_RESP_OKAY);
         rd_chk(`ACR_IDX_LATCHED, pv, `ACR_RESP_OKAY);
         rd_chk(`ACR_IDX_STATUS, {5'h00, 2'(v), 1'b1}, `ACR_RESP_OKAY);
         prev = stage[v];
         pv = view[v];
      end
   endtask

   task automatic t_refused;
      logic [1:0] r;
      rd_chk(8'h10, 8'h00, `ACR_RESP_DECERR);
      axi_write(8'h10, 32'h0000_00FF, r);
      cmp_word(32'(r), 32'(`ACR_RESP_DECERR));
      axi_write(`ACR_IDX_LATCHED, 32'h0000_00FF, r);
      cmp_word(32'(r), 32'(`ACR_RESP_DECERR));
      rd_chk(`ACR_IDX_LATCHED, 8'h81, 2'h0);
   endtask

   task automatic t_mid_reset;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset_values;
   endtask

   // ----------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {aw_valid, w_valid, ar_valid} = 3'b000;
      {b_ready, r_ready} = 2'b11;
      {aw_addr, ar_addr} = 20'h0_0000;
      w_data = 32'h0000_0000;
      w_strb = 4'hF;
      n_mismatch = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset_values;
      t_ident;
      t_snapshots;
      t_refused;
      t_mid_reset;
      test_done;
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      test_done;
   end
endmodule

`default_nettype wire
